/* File: rtl/xlat_consts.svh */
// Named offsets, widths, reset values and figures for the
// translation scheme selector. Included by the package and the top.
`ifndef XLAT_CONSTS_SVH
`define XLAT_CONSTS_SVH

// Register byte offsets, one aligned word each
`define OFF_ATTR 8'h00
`define OFF_SIZES 8'h04
`define OFF_VA_LO 8'h08
`define OFF_VA_HI 8'h0c
`define OFF_STATUS 8'h10
`define OFF_GLOBAL 8'h14
`define OFF_NONE 8'hfc
`define ADDR_W 8

// Field and register widths
`define ATTR_W 10
`define SIZES_W 14
`define VA_W 49
`define VA_LO_W 32
`define SZ32_W 3

// Reset values; attribute reset selects a 4KB granule
`define ATTR_RST 10'h000
`define SIZES_RST 14'h0000

// Address widths in bits
`define IN_32 8'h20
`define IN_WIDE 8'h31
`define OUT_SHORT 8'h20
`define OUT_SHORT_BIG 8'h28
`define OUT_LONG 8'h28
`define OUT_WIDE 8'h30

// Range boundaries: 32-bit and 64-bit address tops
`define BASE32 7'h20
`define BASE64 7'h40
`define WIDE_MIN_SZ 6'h10

// Granule sizes as log2 of bytes
`define GSH_4K 5'h0c
`define GSH_16K 5'h0e
`define GSH_64K 5'h10

`endif

/* File: rtl/xlat_pkg.sv */
// Types for the translation scheme selector.
// Assumes xlat_consts.svh sits on the include path.
`default_nettype none
`include "xlat_consts.svh"
package xlat_pkg;
    typedef enum logic [1:0] {
        SCH_SHORT = 2'h0,
        SCH_LONG = 2'h1,
        SCH_WIDE = 2'h2,
        SCH_BAD = 2'h3
    } scheme_t;
    typedef enum logic [1:0] {
        ARR_S1_BYP = 2'h0,
        ARR_S1_S2 = 2'h1,
        ARR_S2_ONLY = 2'h2,
        ARR_HYP = 2'h3
    } arrange_t;
    typedef enum logic [1:0] {
        GR_4K = 2'h0,
        GR_16K = 2'h1,
        GR_64K = 2'h2,
        GR_BAD = 2'h3
    } granule_t;
    typedef struct packed {
        logic large_pages;
        logic exec64;
        granule_t gran;
        logic monitor;
        logic secure;
        arrange_t arr;
        scheme_t scheme;
    } attr_t;
    typedef struct packed {
        logic [5:0] upper;
        logic [1:0] rsvd;
        logic [5:0] lower;
    } sizes_t;
    typedef struct packed {
        logic cfg_err;
        logic upper_sel;
        logic fault;
        logic desc64;
        logic [7:0] in_bits;
        logic [7:0] out_bits;
        logic [4:0] gran_sh;
    } result_t;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_in_t;
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_out_t;
endpackage : xlat_pkg
`default_nettype wire

/* File: rtl/range_check.sv */
// Picks the lower or upper table base for an input address and
// flags addresses in the gap. Purely combinational.
`default_nettype none
`include "xlat_consts.svh"
module range_check (
    input wire xlat_pkg::scheme_t scheme,
    input wire xlat_pkg::sizes_t sizes,
    input wire logic [`VA_W-1:0] va,
    output logic upper_sel,
    output logic fault
);
    import xlat_pkg::*;

    // Bits from base-sz up to base-1 inside the 49-bit model
    function automatic logic [`VA_W-1:0] hi_mask(
        input logic [6:0] base, input logic [5:0] sz);
        logic [`VA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `VA_W; i++) begin
            m[i] = (7'(i) < base) && (7'(i) + {1'b0, sz} >= base);
        end
        return m;
    endfunction : hi_mask

    logic [5:0] lo_sz, hi_sz;
    logic [`VA_W-1:0] m_lo, m_hi;
    logic lo_ok, hi_ok, over32;

    // Masks use 3-bit fields for 32-bit input, clamped 6-bit for wide
    always_comb begin
        lo_sz = {3'h0, sizes.lower[`SZ32_W-1:0]};
        hi_sz = {3'h0, sizes.upper[`SZ32_W-1:0]};
        over32 = |va[`VA_W-1:`VA_LO_W];
        if (scheme == SCH_WIDE) begin
            // Below the minimum the range would pass 48 bits
            lo_sz = (sizes.lower < `WIDE_MIN_SZ) ? `WIDE_MIN_SZ : sizes.lower;
            hi_sz = (sizes.upper < `WIDE_MIN_SZ) ? `WIDE_MIN_SZ : sizes.upper;
            m_lo = hi_mask(`BASE64, lo_sz);
            m_hi = hi_mask(`BASE64, hi_sz);
            over32 = 1'b0;
        end else begin
            m_lo = hi_mask(`BASE32, lo_sz);
            m_hi = hi_mask(`BASE32, hi_sz);
        end
        lo_ok = (va & m_lo) == '0;
        hi_ok = (va & m_hi) == m_hi;
        upper_sel = 1'b0;
        fault = 1'b0;
        unique case (scheme)
            SCH_SHORT: begin
                // Zero size field leaves the upper base unused
                upper_sel = (lo_sz != 6'h0) && !lo_ok;
                fault = over32;
            end
            SCH_LONG: begin
                // One size left at zero: its base takes the rest of the range
                if (hi_sz == 6'h0) begin
                    hi_ok = (lo_sz != 6'h0) && !lo_ok;
                end else if (lo_sz == 6'h0) begin
                    lo_ok = !hi_ok;
                end
                upper_sel = !lo_ok && hi_ok;
                fault = over32 || (!lo_ok && !hi_ok);
            end
            SCH_WIDE: begin
                // Top bits all zero or all one, anything else is gap
                upper_sel = hi_ok;
                fault = !lo_ok && !hi_ok;
            end
            SCH_BAD: begin
                fault = 1'b1;
            end
        endcase
    end
endmodule : range_check
`default_nettype wire

/* File: rtl/translation_scheme_select.sv */
// Translation scheme selector for one context bank: holds the
// context attributes, range size fields and a probe address, checks
// the scheme against the stage arrangement and reports the chosen
// table base, gap faults and address widths.
// Assumes a single AHB-Lite master on core_clk and a synchronous,
// active-low reset.
`default_nettype none
`include "xlat_consts.svh"
module translation_scheme_select (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire xlat_pkg::ahb_in_t ahb_i,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output xlat_pkg::result_t res_o
);
    import xlat_pkg::*;

    typedef struct packed {
        attr_t attr;
        sizes_t sizes;
        logic [`VA_W-1:0] va;
        logic ns_hyp;
        logic ap_wr;
        logic [`ADDR_W-1:0] ap_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        result_t res;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic take;
    logic bank_locked;
    logic sel_upper;
    logic gap_fault;

    // Configuration legality for the chosen arrangement
    function automatic logic cfg_bad(input attr_t a);
        logic bad;
        bad = (a.scheme == SCH_BAD);
        // Short scheme allowed only as a first stage
        if (a.scheme == SCH_SHORT && a.arr != ARR_S1_BYP
                && a.arr != ARR_S1_S2) begin
            bad = 1'b1;
        end
        if (a.arr == ARR_HYP && !a.exec64 && a.scheme != SCH_LONG) begin
            bad = 1'b1;
        end
        if (a.monitor && (a.arr != ARR_S1_BYP || !a.secure)) begin
            bad = 1'b1;
        end
        if (a.exec64 && a.scheme != SCH_WIDE) begin
            bad = 1'b1;
        end
        if (a.scheme != SCH_WIDE && a.gran != GR_4K) begin
            bad = 1'b1;
        end
        if (a.gran == GR_BAD) begin
            bad = 1'b1;
        end
        // Second-stage-only serves the non-secure address space
        if (a.arr == ARR_S2_ONLY && a.secure) begin
            bad = 1'b1;
        end
        return bad;
    endfunction : cfg_bad

    // Output address width for a scheme
    function automatic logic [7:0] out_width(input attr_t a);
        unique case (a.scheme)
            SCH_SHORT: return a.large_pages ? `OUT_SHORT_BIG : `OUT_SHORT;
            SCH_LONG: return `OUT_LONG;
            SCH_WIDE: return `OUT_WIDE;
            SCH_BAD: return 8'h00;
        endcase
    endfunction : out_width

    // Granule size as a shift
    function automatic logic [4:0] gran_shift(input granule_t g);
        unique case (g)
            GR_4K: return `GSH_4K;
            GR_16K: return `GSH_16K;
            GR_64K: return `GSH_64K;
            GR_BAD: return 5'h00;
        endcase
    endfunction : gran_shift

    // Read mux; narrow registers sit in the low bits
    function automatic logic [31:0] rd_mux(
        input state_t s, input logic [`ADDR_W-1:0] a);
        unique case (a)
            `OFF_ATTR: return 32'(s.attr);
            `OFF_SIZES: return 32'(s.sizes);
            `OFF_VA_LO: return s.va[`VA_LO_W-1:0];
            `OFF_VA_HI: return 32'(s.va[`VA_W-1:`VA_LO_W]);
            `OFF_STATUS: return 32'(s.res);
            `OFF_GLOBAL: return 32'(s.ns_hyp);
            default: return 32'h0000_0000;
        endcase
    endfunction : rd_mux

    range_check u_range (
        .scheme(st_r.attr.scheme),
        .sizes(st_r.sizes),
        .va(st_r.va),
        .upper_sel(sel_upper),
        .fault(gap_fault)
    );

    // Bus slave, register writes and probe result
    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = 1'b1;
        st_nxt.resp = 1'b0;
        take = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
        // A hypervisor-level writer may not change a secure bank's attributes or sizes
        bank_locked = st_r.ns_hyp && st_r.attr.secure;

        // Data phase of a write
        if (st_r.ap_wr) begin
            unique case (st_r.ap_addr)
                `OFF_ATTR: begin
                    if (!bank_locked) begin
                        st_nxt.attr = attr_t'(ahb_i.hwdata[`ATTR_W-1:0]);
                        // Hypervisor level cannot make a bank secure
                        if (st_r.ns_hyp) begin
                            st_nxt.attr.secure = 1'b0;
                        end
                    end
                end
                `OFF_SIZES: begin
                    if (!bank_locked) begin
                        st_nxt.sizes = sizes_t'(ahb_i.hwdata[`SIZES_W-1:0]);
                        st_nxt.sizes.rsvd = 2'h0;
                    end
                end
                `OFF_VA_LO: begin
                    st_nxt.va[`VA_LO_W-1:0] = ahb_i.hwdata;
                end
                `OFF_VA_HI: begin
                    st_nxt.va[`VA_W-1:`VA_LO_W] =
                        ahb_i.hwdata[`VA_W-`VA_LO_W-1:0];
                end
                `OFF_GLOBAL: begin
                    st_nxt.ns_hyp = ahb_i.hwdata[0];
                end
                default: begin
                end
            endcase
        end

        // Address phase; unmapped high addresses decode to a hole
        st_nxt.ap_wr = take && ahb_i.hwrite;
        st_nxt.ap_addr = (ahb_i.haddr[31:`ADDR_W] == '0)
            ? ahb_i.haddr[`ADDR_W-1:0] : `OFF_NONE;
        // Read from the next state so a write just before is seen
        st_nxt.rdata = (take && !ahb_i.hwrite)
            ? rd_mux(st_nxt, st_nxt.ap_addr) : 32'h0000_0000;

        // Probe result, one cycle behind the stored settings
        st_nxt.res.cfg_err = cfg_bad(st_r.attr);
        st_nxt.res.fault = gap_fault;
        st_nxt.res.upper_sel = sel_upper && !gap_fault;
        st_nxt.res.desc64 = (st_r.attr.scheme != SCH_SHORT);
        st_nxt.res.in_bits = (st_r.attr.scheme == SCH_WIDE)
            ? `IN_WIDE : `IN_32;
        st_nxt.res.out_bits = out_width(st_r.attr);
        st_nxt.res.gran_sh = gran_shift(st_r.attr.gran);
    end

    // Single state register; reset leaves a 4KB short context
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.attr <= attr_t'(`ATTR_RST);
            st_r.sizes <= sizes_t'(`SIZES_RST);
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign hrdata = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp = st_r.resp;
    assign res_o = st_r.res;

    // Descriptor width follows the scheme
    desc_width_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |->
        st_r.res.desc64 == ($past(st_r.attr.scheme) != SCH_SHORT))
    else $error("descriptor width does not match scheme");

    // Short scheme widths
    short_width_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_SHORT) |=>
        st_r.res.in_bits == `IN_32 &&
        st_r.res.out_bits ==
            ($past(st_r.attr.large_pages) ? `OUT_SHORT_BIG : `OUT_SHORT))
    else $error("short scheme widths wrong");

    // Short scheme never as a second stage
    short_stage_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_SHORT &&
         (st_r.attr.arr == ARR_S2_ONLY || st_r.attr.arr == ARR_HYP))
        |=> st_r.res.cfg_err)
    else $error("short scheme accepted on second stage");

    // Long scheme widths
    long_width_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_LONG) |=>
        st_r.res.out_bits == `OUT_LONG && st_r.res.in_bits == `IN_32)
    else $error("long scheme widths wrong");

    // Wide scheme widths
    wide_width_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_WIDE) |=>
        st_r.res.out_bits == `OUT_WIDE && st_r.res.in_bits == `IN_WIDE)
    else $error("wide scheme widths wrong");

    // 32-bit-input schemes stay at 4KB
    gran_fixed_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme != SCH_WIDE && st_r.attr.gran != GR_4K)
        |=> st_r.res.cfg_err)
    else $error("granule other than 4KB accepted");

    // Gap between wide subranges faults
    wide_gap_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_WIDE &&
         st_r.sizes.lower > `WIDE_MIN_SZ &&
         st_r.sizes.upper > `WIDE_MIN_SZ &&
         !st_r.va[`VA_W-1] && st_r.va[`VA_W-2])
        |=> st_r.res.fault && !st_r.res.upper_sel)
    else $error("gap address not faulted");

    // All-ones top bits pick the upper base
    wide_upper_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_WIDE && (&st_r.va[`VA_W-1:1]))
        |=> st_r.res.upper_sel && !st_r.res.fault)
    else $error("upper base not chosen");

    // All-zero top bits pick the lower base
    wide_lower_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_WIDE && st_r.va[`VA_W-1:1] == '0)
        |=> !st_r.res.upper_sel && !st_r.res.fault)
    else $error("lower base not chosen");

    // Hypervisor-level attribute and size writes leave a secure bank alone
    hyp_lock_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.ap_wr && st_r.ns_hyp && st_r.attr.secure &&
         (st_r.ap_addr == `OFF_ATTR || st_r.ap_addr == `OFF_SIZES))
        |=> $stable(st_r.attr) && $stable(st_r.sizes))
    else $error("secure bank changed by hypervisor write");

    // 64-bit execution needs the wide scheme
    exec_wide_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.exec64 && st_r.attr.scheme != SCH_WIDE)
        |=> st_r.res.cfg_err)
    else $error("non-wide scheme accepted for 64-bit execution");

    // Monitor context only as first stage with bypass
    monitor_ctx_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.monitor && st_r.attr.arr != ARR_S1_BYP)
        |=> st_r.res.cfg_err)
    else $error("monitor context in wrong arrangement");

    // Hypervisor context on 32-bit input uses the long scheme
    hyp_scheme_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.arr == ARR_HYP && !st_r.attr.exec64 &&
         st_r.attr.scheme != SCH_LONG)
        |=> st_r.res.cfg_err)
    else $error("hypervisor context scheme accepted");

    // Second-stage-only context stays non-secure
    stage2_only_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.arr == ARR_S2_ONLY && st_r.attr.secure)
        |=> st_r.res.cfg_err)
    else $error("secure second-stage-only context accepted");

    // Hypervisor-level attribute writes never make a bank secure
    hyp_clear_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.ap_wr && st_r.ns_hyp && !st_r.attr.secure &&
         st_r.ap_addr == `OFF_ATTR)
        |=> !st_r.attr.secure)
    else $error("hypervisor write made a bank secure");

    // Wide scheme with the 16KB granule reports the 16KB shift
    wide_gran_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_WIDE && st_r.attr.gran == GR_16K)
        |=> st_r.res.gran_sh == `GSH_16K)
    else $error("wide scheme granule size wrong");

    // Long scheme with only the upper size set still reaches the upper base
    long_upper_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (st_r.attr.scheme == SCH_LONG && st_r.sizes.lower[`SZ32_W-1:0] == 3'h0 &&
         st_r.sizes.upper[`SZ32_W-1:0] != 3'h0 &&
         st_r.va[`VA_W-1:`VA_LO_W] == '0 && (&st_r.va[`VA_LO_W-1:0]))
        |=> st_r.res.upper_sel && !st_r.res.fault)
    else $error("upper base not chosen for long scheme");

    // Zero-wait bus answer with OKAY
    bus_ready_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> hreadyout && !hresp)
    else $error("slave stalled or erred");
endmodule : translation_scheme_select
`default_nettype wire

/* File: tb/ahb_master_model.sv */
// Single-transfer AHB-Lite master standing in for the bus side.
// Assumes a zero-or-more wait slave whose hreadyout is the bus hready.
`default_nettype none
module ahb_master_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    output xlat_pkg::ahb_in_t bus_o,
    output logic [31:0] rdata,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    import xlat_pkg::*;
    logic [1:0] phase_r = 2'h0;
    logic [31:0] wbuf_r = 32'h0;

    // Known values before the first edge
    initial begin
        bus_o = '{hsel: 1'b1, hsize: 3'h2, default: '0};
        rdata = 32'h0;
        done = 1'b0;
    end

    // Idle until go, then address phase and data phase, each held until hready
    always @(posedge core_clk) begin
        done <= (phase_r == 2'h2) && hreadyout;
        if (!reset_n) begin
            phase_r <= 2'h0;
            bus_o <= '{hsel: 1'b1, hsize: 3'h2, default: '0};
        end else begin
            case (phase_r)
                2'h0: if (go) begin
                    bus_o.haddr <= addr;
                    bus_o.htrans <= 2'h2;
                    bus_o.hwrite <= wr;
                    wbuf_r <= wdata;
                    phase_r <= 2'h1;
                end
                2'h1: if (hreadyout) begin
                    bus_o.htrans <= 2'h0;
                    bus_o.hwdata <= wbuf_r;
                    phase_r <= 2'h2;
                end
                default: if (hreadyout) begin
                    rdata <= hrdata;
                    // Released lines flip so stale data never looks valid
                    bus_o.hwdata <= ~bus_o.hwdata;
                    bus_o.haddr <= ~bus_o.haddr;
                    phase_r <= 2'h0;
                end
            endcase
        end
    end
endmodule : ahb_master_model
`default_nettype wire

/* File: tb/translation_scheme_select_test.sv */
// Register-level test of the translation scheme selector.
// Assumes the AHB master model and the design files are compiled first.
`default_nettype none
`include "xlat_consts.svh"
module translation_scheme_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import xlat_pkg::*;
    localparam logic [24:0] MA = 25'h1ffffff;
    localparam logic [24:0] ME = 25'h1000000;
    localparam logic [24:0] MS = 25'h0c00000;
    localparam logic [24:0] UP = 25'h0800000;
    localparam logic [24:0] FL = 25'h0400000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_go = 1'b0;
    logic cmd_wr = 1'b0;
    logic [31:0] cmd_addr = 32'h0;
    logic [31:0] cmd_data = 32'h0;
    logic [31:0] cmd_rdata;
    logic cmd_done;
    ahb_in_t m_bus;
    ahb_in_t bus;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    result_t res_o;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] d;

    always #2 core_clk = ~core_clk;

    // Bus hready is the one slave's hreadyout
    always_comb begin
        bus = m_bus;
        bus.hready = hreadyout;
    end

    translation_scheme_select dut (.core_clk(core_clk), .reset_n(reset_n), .ahb_i(bus),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .res_o(res_o));

    ahb_master_model master (.core_clk(core_clk), .reset_n(reset_n), .go(cmd_go),
        .wr(cmd_wr), .addr(cmd_addr), .wdata(cmd_data), .hrdata(hrdata),
        .hreadyout(hreadyout), .bus_o(m_bus), .rdata(cmd_rdata), .done(cmd_done));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // One whole transfer; only the hang guard ends a stuck wait
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge core_clk);
        cmd_go <= 1'b1;
        cmd_wr <= w;
        cmd_addr <= a;
        cmd_data <= wd;
        @(posedge core_clk);
        cmd_go <= 1'b0;
        do begin
            @(posedge core_clk);
            #1;
        end while (cmd_done !== 1'b1);
        rd = cmd_rdata;
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] x;
        xfer(1'b1, a, wd, x);
    endtask : wr

    function automatic logic [24:0] f(input int d64, input logic [7:0] i,
        input logic [7:0] o, input logic [4:0] g);
        return {3'h0, d64[0], i, o, g};
    endfunction : f

    // Programs one context and checks the probe and its status copy
    task automatic run(input logic [9:0] at, input logic [13:0] sz, input logic [16:0] vh,
        input logic [31:0] vl, input logic [24:0] m, input logic [24:0] ex);
        logic [31:0] s;
        wr(`OFF_ATTR, {22'h0, at});
        wr(`OFF_SIZES, {18'h0, sz});
        wr(`OFF_VA_LO, vl);
        wr(`OFF_VA_HI, {15'h0, vh});
        repeat (2) @(posedge core_clk);
        #1;
        chk({7'h0, res_o & m}, {7'h0, ex & m});
        xfer(1'b0, `OFF_STATUS, 32'h0, s);
        chk({7'h0, s[24:0] & m}, {7'h0, ex & m});
    endtask : run

    // Hang guard, well above the length of the sequence
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk({7'h0, res_o}, {7'h0, f(0, `IN_32, `OUT_SHORT, `GSH_4K)});
        chk({30'h0, hresp, hreadyout}, 32'h1);
        xfer(1'b0, `OFF_ATTR, 32'h0, d);
        chk(d, 32'h0);
        // Reserved size bits read zero; unmapped places read zero
        wr(`OFF_SIZES, 32'hffffffff);
        xfer(1'b0, `OFF_SIZES, 32'h0, d);
        chk(d, 32'h00003f3f);
        wr(`OFF_NONE, 32'hffffffff);
        xfer(1'b0, `OFF_NONE, 32'h0, d);
        chk(d, 32'h0);
        xfer(1'b0, 32'h00000100, 32'h0, d);
        chk(d, 32'h0);
        // Hypervisor-level writer: cannot set secure; secure bank sizes untouchable
        wr(`OFF_GLOBAL, 32'h1);
        wr(`OFF_ATTR, 32'h011);
        xfer(1'b0, `OFF_ATTR, 32'h0, d);
        chk(d, 32'h001);
        wr(`OFF_GLOBAL, 32'h0);
        wr(`OFF_ATTR, 32'h011);
        wr(`OFF_GLOBAL, 32'h1);
        wr(`OFF_SIZES, 32'h0101);
        xfer(1'b0, `OFF_SIZES, 32'h0, d);
        chk(d, 32'h00003f3f);
        wr(`OFF_GLOBAL, 32'h0);
        // Widths, descriptor size and granule per scheme
        run(10'h200, 14'h0, 17'h0, 32'h0, MA, f(0, `IN_32, `OUT_SHORT_BIG, `GSH_4K));
        run(10'h001, 14'h0, 17'h0, 32'h0, MA, f(1, `IN_32, `OUT_LONG, `GSH_4K));
        run(10'h102, 14'h0, 17'h0, 32'h0, MA, f(1, `IN_WIDE, `OUT_WIDE, `GSH_4K));
        run(10'h142, 14'h0, 17'h0, 32'h0, MA, f(1, `IN_WIDE, `OUT_WIDE, `GSH_16K));
        run(10'h182, 14'h0, 17'h0, 32'h0, MA, f(1, `IN_WIDE, `OUT_WIDE, `GSH_64K));
        // Legal and illegal stage arrangements, 64-bit execution and granules
        run(10'h008, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h00c, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h00d, 14'h0, 17'h0, 32'h0, ME, 25'h0);
        run(10'h030, 14'h0, 17'h0, 32'h0, ME, 25'h0);
        run(10'h034, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h020, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h005, 14'h0, 17'h0, 32'h0, ME, 25'h0);
        run(10'h009, 14'h0, 17'h0, 32'h0, ME, 25'h0);
        run(10'h019, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h101, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h041, 14'h0, 17'h0, 32'h0, ME, ME);
        run(10'h0c2, 14'h0, 17'h0, 32'h0, ME, ME);
        // Subrange choice and gap faults at the boundaries
        run(10'h000, 14'h0001, 17'h0, 32'h80000000, MS, UP);
        run(10'h000, 14'h0001, 17'h0, 32'h7fffffff, MS, 25'h0);
        run(10'h000, 14'h0000, 17'h0, 32'hffffffff, MS, 25'h0);
        run(10'h000, 14'h0000, 17'h1, 32'h0, MS, FL);
        run(10'h001, 14'h0202, 17'h0, 32'h3fffffff, MS, 25'h0);
        run(10'h001, 14'h0202, 17'h0, 32'hc0000000, MS, UP);
        run(10'h001, 14'h0202, 17'h0, 32'h40000000, MS, FL);
        run(10'h001, 14'h0200, 17'h0, 32'hffffffff, MS, UP);
        run(10'h001, 14'h0200, 17'h0, 32'hbfffffff, MS, 25'h0);
        run(10'h102, 14'h1111, 17'h18000, 32'h0, MS, UP);
        run(10'h102, 14'h1111, 17'h00000, 32'hffffffff, MS, 25'h0);
        run(10'h102, 14'h1111, 17'h08000, 32'h0, MS, FL);
        run(10'h102, 14'h1111, 17'h10000, 32'h0, MS, FL);
        run(10'h102, 14'h0000, 17'h10000, 32'h0, MS, UP);
        complete_run();
    end
endmodule : translation_scheme_select_test
`default_nettype wire
